//--- verilog/pspc_core.sv
// Core end: sleep and pause halting of the processor pipeline
`timescale 1ns/100ps
module pspc_core (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Link to external control
    pspc_if.core            lnk,
    // Pipeline side
    input  wire logic       barrier_valid,
    input  wire logic [4:0] barrier_code,
    input  wire logic       accesses_busy,
    input  wire logic       dbg_wake_cmd,
    input  wire logic       dbg_continue_cmd,
    output logic            pipe_halt,
    output logic            resume_pulse
);

    // ****************************************************
    // Resume input synchronisers
    // ****************************************************
    logic [1:0] wake_s1_reg;
    logic [1:0] wake_s1_next;
    logic [1:0] wake_s2_reg;
    logic [1:0] wake_s2_next;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_comb begin
                wake_s1_next[gi] = lnk.wake_req[gi];
                wake_s2_next[gi] = wake_s1_reg[gi];
            end

            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    wake_s1_reg[gi] <= 1'h0;
                    wake_s2_reg[gi] <= 1'h0;
                end else begin
                    wake_s1_reg[gi] <= wake_s1_next[gi];
                    wake_s2_reg[gi] <= wake_s2_next[gi];
                end
            end
        end
    endgenerate

    // ****************************************************
    // Barrier decode
    // ****************************************************
    logic [2:0] code_kind;

    always_comb begin
        case (barrier_code)
            pspc_pkg::CODE_LIGHT: begin
                code_kind = 3'h1;
            end
            pspc_pkg::CODE_HIBERNATE: begin
                code_kind = 3'h2;
            end
            pspc_pkg::CODE_SUSPEND: begin
                code_kind = 3'h4;
            end
            default: begin
                // Any other code leaves the core running
                code_kind = 3'h0;
            end
        endcase
    end

    // ****************************************************
    // Halt state machine
    // ****************************************************
    pspc_pkg::pspc_state_t state_reg, state_next;
    logic [2:0] kind_reg, kind_next;
    logic [2:0] slp_out_reg, slp_out_next;
    logic       ack_reg, ack_next;

    always_comb begin
        state_next   = state_reg;
        kind_next    = kind_reg;
        slp_out_next = slp_out_reg;
        ack_next     = ack_reg;
        case (state_reg)
            pspc_pkg::PSPC_RUN: begin
                if (barrier_valid && (|code_kind)) begin
                    kind_next  = code_kind;
                    state_next = pspc_pkg::PSPC_DRAIN_SLP;
                end else if (lnk.pause) begin
                    state_next = pspc_pkg::PSPC_DRAIN_PSE;
                end
            end
            pspc_pkg::PSPC_DRAIN_SLP: begin
                if (!accesses_busy) begin
                    slp_out_next = kind_reg;
                    state_next   = pspc_pkg::PSPC_SLEEP;
                end
            end
            pspc_pkg::PSPC_SLEEP: begin
                if (|wake_s2_reg) begin
                    slp_out_next = 3'h0;
                    state_next   = pspc_pkg::PSPC_RUN;
                end
            end
            pspc_pkg::PSPC_DRAIN_PSE: begin
                if (!accesses_busy) begin
                    ack_next   = 1'h1;
                    state_next = pspc_pkg::PSPC_PAUSED;
                end
            end
            pspc_pkg::PSPC_PAUSED: begin
                if (!lnk.pause) begin
                    ack_next    = 1'h0;
                    state_next  = pspc_pkg::PSPC_RUN;
                end
            end
            default: begin
                state_next   = pspc_pkg::PSPC_RUN;
                slp_out_next = 3'h0;
                ack_next     = 1'h0;
            end
        endcase
    end

    // State, sleep kind, sleep outputs and acknowledge on ref_clk directly
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg   <= pspc_pkg::PSPC_RUN;
            kind_reg    <= 3'h0;
            slp_out_reg <= 3'h0;
            ack_reg     <= 1'h0;
        end else begin
            state_reg   <= state_next;
            kind_reg    <= kind_next;
            slp_out_reg <= slp_out_next;
            ack_reg     <= ack_next;
        end
    end

    // ****************************************************
    // Resume pulse
    // ****************************************************
    logic resume_reg, resume_next;

    always_comb begin
        resume_next = 1'h0;
        if (state_next == pspc_pkg::PSPC_RUN && (state_reg == pspc_pkg::PSPC_SLEEP
                || state_reg == pspc_pkg::PSPC_PAUSED)) begin
            resume_next = 1'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            resume_reg <= 1'h0;
        end else begin
            resume_reg <= resume_next;
        end
    end

    // ****************************************************
    // Debug requests
    // ****************************************************
    logic dbgw_reg, dbgw_next;
    logic dbgc_reg, dbgc_next;

    always_comb begin
        dbgw_next = dbg_wake_cmd;
        dbgc_next = dbg_continue_cmd;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dbgw_reg <= 1'h0;
            dbgc_reg <= 1'h0;
        end else begin
            dbgw_reg <= dbgw_next;
            dbgc_reg <= dbgc_next;
        end
    end

    // ****************************************************
    // Sleep outputs
    // ****************************************************
    // Sleep outputs flag safe stop
    assign lnk.light_sleep  = slp_out_reg[0];
    assign lnk.hibernate    = slp_out_reg[1];
    assign lnk.suspend      = slp_out_reg[2];

    // ****************************************************
    // Pause and debug outputs
    // ****************************************************
    assign lnk.pause_ack    = ack_reg;
    // Debug request registered on single clock
    assign lnk.dbg_wake_req = dbgw_reg;
    assign lnk.dbg_continue = dbgc_reg;
    assign pipe_halt        = (state_reg != pspc_pkg::PSPC_RUN);
    assign resume_pulse     = resume_reg;

endmodule

//--- verilog/pspc_pkg.sv
// Package of constants for the sleep and pause control block
package pspc_pkg;

    // ****************************************************
    // Barrier codes and sleep kinds
    // ****************************************************
    localparam logic [4:0] CODE_LIGHT     = 5'h10;
    localparam logic [4:0] CODE_HIBERNATE = 5'h08;
    localparam logic [4:0] CODE_SUSPEND   = 5'h18;
    localparam int         SYNC_STAGES    = 2;
    localparam logic       GATE_RESET_VAL = 1'h1;

    typedef enum logic [2:0] {
        PSPC_RUN       = 3'b000,
        PSPC_DRAIN_SLP = 3'b001,
        PSPC_SLEEP     = 3'b010,
        PSPC_DRAIN_PSE = 3'b011,
        PSPC_PAUSED    = 3'b100
    } pspc_state_t;

endpackage

//--- verilog/pspc_if.sv
// Interface joining the core halt logic to the external clock control
`timescale 1ns/100ps
interface pspc_if;
    logic       light_sleep;
    logic       hibernate;
    logic       suspend;
    logic [1:0] wake_req;
    logic       dbg_wake_req;
    logic       pause;
    logic       pause_ack;
    logic       dbg_continue;

    modport core (output light_sleep, hibernate, suspend, dbg_wake_req, pause_ack,
                  dbg_continue, input wake_req, pause);
    modport ctrl (input light_sleep, hibernate, suspend, dbg_wake_req, pause_ack,
                  dbg_continue, output wake_req, pause);
endinterface

//--- verilog/pspc_ctrl.sv
// External end: wake routing, pause request and clock gate enable
`timescale 1ns/100ps
module pspc_ctrl (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic gate_rst,
    // Link to the core
    pspc_if.ctrl      lnk,
    // System side
    input  wire logic irq,
    input  wire logic pause_cmd,
    output logic      clk_en,
    output logic      sys_reset_req
);

    // ****************************************************
    // Wake routing
    // ****************************************************
    // Interrupt and debug request wake
    assign lnk.wake_req = {lnk.dbg_wake_req, irq};
    assign sys_reset_req = lnk.suspend;

    // ****************************************************
    // Pause request
    // ****************************************************
    logic pause_reg, pause_next;

    always_comb begin
        pause_next = pause_reg;
        if (pause_reg == lnk.pause_ack) begin
            pause_next = pause_cmd && !lnk.dbg_continue;
        end
    end

    // ****************************************************
    // Clock gate enable
    // ****************************************************
    logic gate_reg, gate_next;

    always_comb begin
        gate_next = gate_reg;
        if (lnk.light_sleep && !irq && !lnk.dbg_wake_req) begin
            gate_next = 1'h0;
        end else if (!gate_reg) begin
            gate_next = 1'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (gate_rst) begin
            gate_reg  <= pspc_pkg::GATE_RESET_VAL;
            pause_reg <= 1'h0;
        end else begin
            gate_reg  <= gate_next;
            pause_reg <= pause_next;
        end
    end

    assign clk_en    = gate_reg && !(pause_reg && lnk.pause_ack);
    assign lnk.pause = pause_reg;

endmodule

//--- tb/pspc_chk.sv
// Checker of the sleep and pause handshake on the link
`timescale 1ns/100ps
module pspc_chk (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       nrst,
    // Link signals
    input wire logic       light_sleep,
    input wire logic       hibernate,
    input wire logic       suspend,
    input wire logic [1:0] wake_req,
    input wire logic       pause,
    input wire logic       pause_ack
);
    wire logic [2:0] slp = {suspend, hibernate, light_sleep};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // Properties
    // ****************************************
    AST_ONE_SLEEP: assert property ($onehot0(slp))
        else $error("more than one sleep output");
    AST_WAKE_DROP: assert property ((|slp) && (|wake_req) |-> ##[1:4] !(|slp))
        else $error("sleep output kept after wake");
    AST_SLEEP_HOLD: assert property (((|slp) && !(|wake_req))[*4] |=> $stable(slp))
        else $error("sleep output moved without wake");
    AST_ACK_RISE: assert property ($rose(pause_ack) |-> pause)
        else $error("acknowledge without pause");
    AST_ACK_HOLD: assert property (pause_ack && pause |=> pause_ack)
        else $error("acknowledge dropped while paused");
    AST_ACK_DROP: assert property (pause_ack && !pause |=> !pause_ack)
        else $error("acknowledge kept after release");
    AST_ACK_EXCL: assert property (pause_ack |-> !(|slp))
        else $error("pause and sleep together");
    AST_PAUSE_ORDER: assert property ($changed(pause) |-> $past(pause) == $past(pause_ack))
        else $error("pause changed before acknowledge");
    cover property ($rose(light_sleep));
    cover property ($rose(hibernate));
    cover property ($rose(suspend));
    cover property ($fell(pause_ack));
endmodule

//--- tb/test_processor_sleep_pause_control.sv
// Testbench of both ends of the sleep and pause control
`timescale 1ns/100ps
module test_processor_sleep_pause_control;
    logic       ref_clk = 1'h0;
    logic       nrst = 1'h0;
    logic       gate_rst = 1'h1;
    logic       barrier_valid = 1'h0;
    logic [4:0] barrier_code = 5'h00;
    logic       accesses_busy = 1'h0;
    logic       dbg_wake_cmd = 1'h0;
    logic       dbg_continue_cmd = 1'h0;
    logic       irq = 1'h0;
    logic       pause_cmd = 1'h0;
    logic       pipe_halt, resume_pulse, clk_en, sys_reset_req, seen_res;
    int         failures = 0;
    int         checked = 0;
    pspc_if lnk();
    wire logic [2:0] slp = {lnk.suspend, lnk.hibernate, lnk.light_sleep};
    wire logic [4:0] obs = {lnk.dbg_continue, lnk.pause_ack, slp};
    pspc_core u_pspc_core (.ref_clk, .nrst, .lnk, .barrier_valid, .barrier_code,
        .accesses_busy, .dbg_wake_cmd, .dbg_continue_cmd, .pipe_halt, .resume_pulse);
    pspc_ctrl u_pspc_ctrl (.ref_clk, .gate_rst, .lnk, .irq, .pause_cmd, .clk_en,
        .sys_reset_req);
    pspc_chk u_pspc_chk (.ref_clk, .nrst, .light_sleep(lnk.light_sleep),
        .hibernate(lnk.hibernate), .suspend(lnk.suspend), .wake_req(lnk.wake_req),
        .pause(lnk.pause), .pause_ack(lnk.pause_ack));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (resume_pulse === 1'h1) seen_res <= 1'h1;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic complete_run();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        while (obs[b] !== v && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        chk("wait", {2'h0, v}, {2'h0, obs[b]});
        if (obs[b] !== v) complete_run();
    endtask
    task automatic do_sleep(input logic [4:0] code, input int b, input logic dbg);
        @(negedge ref_clk);
        accesses_busy = 1'h1;
        barrier_code = code;
        barrier_valid = 1'h1;
        @(negedge ref_clk);
        barrier_valid = 1'h0;
        repeat (4) @(negedge ref_clk);
        chk("sleep while busy", 3'h0, slp);
        accesses_busy = 1'h0;
        wait_bit(b, 1'h1);
        chk("sleep kind", 3'h1 << b, slp);
        chk("halt", 3'h1, {2'h0, pipe_halt});
        chk("reset request", {2'h0, b == 2}, {2'h0, sys_reset_req});
        repeat (3) @(negedge ref_clk);
        if (b == 0) chk("gate off", 3'h0, {2'h0, clk_en});
        seen_res = 1'h0;
        if (dbg) dbg_wake_cmd = 1'h1;
        else irq = 1'h1;
        wait_bit(b, 1'h0);
        repeat (2) @(negedge ref_clk);
        chk("gate on", 3'h1, {2'h0, clk_en});
        chk("resume pulse", 3'h1, {2'h0, seen_res});
        irq = 1'h0;
        dbg_wake_cmd = 1'h0;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge ref_clk);
        nrst = 1'h1;
        gate_rst = 1'h0;
        irq = 1'h1;
        barrier_code = 5'h04;
        barrier_valid = 1'h1;
        @(negedge ref_clk);
        barrier_valid = 1'h0;
        repeat (8) @(negedge ref_clk);
        chk("refused code", 3'h0, slp);
        chk("no halt", 3'h0, {2'h0, pipe_halt});
        irq = 1'h0;
        do_sleep(pspc_pkg::CODE_LIGHT, 0, 1'h0);
        do_sleep(pspc_pkg::CODE_HIBERNATE, 1, 1'h1);
        do_sleep(pspc_pkg::CODE_SUSPEND, 2, 1'h0);
        accesses_busy = 1'h1;
        pause_cmd = 1'h1;
        repeat (5) @(negedge ref_clk);
        chk("ack while busy", 3'h0, {2'h0, lnk.pause_ack});
        accesses_busy = 1'h0;
        wait_bit(3, 1'h1);
        chk("pause halt", 3'h1, {2'h0, pipe_halt});
        repeat (2) @(negedge ref_clk);
        chk("paused gate", 3'h0, {2'h0, clk_en});
        dbg_continue_cmd = 1'h1;
        wait_bit(4, 1'h1);
        pause_cmd = 1'h0;
        dbg_continue_cmd = 1'h0;
        wait_bit(3, 1'h0);
        repeat (2) @(negedge ref_clk);
        chk("resumed gate", 3'h1, {2'h0, clk_en});
        chk("resumed", 3'h0, {2'h0, pipe_halt});
        complete_run();
    end
endmodule
